// File: ptp_port_params.svh
// Offsets, field positions, reset values and constants of the port status
// block. Assumes a 32-bit register port with an 8-bit byte address.
`ifndef PTP_PORT_PARAMS_SVH
`define PTP_PORT_PARAMS_SVH

`define REG_MODE_OFS     8'h00
`define REG_CTRL_OFS     8'h04
`define REG_STATE_OFS    8'h08
`define REG_SERVO_OFS    8'h0C
`define REG_ID_HI_OFS    8'h10
`define REG_ID_LO_OFS    8'h14

`define MODE_RESET       2'h1
`define CTRL_RESTART_BIT 0
`define EUI_FILL         16'hFFFE

`endif

// File: ptp_port_pkg.sv
// Types shared by the port status block and its surroundings.
// Assumes the message classifier upstream tags each frame with a class.
package ptp_port_pkg;

    typedef enum logic [3:0] {
        PS_INITIALIZING, PS_FAULTY, PS_DISABLED, PS_LISTENING,
        PS_PRE_MASTER, PS_MASTER, PS_PASSIVE, PS_UNCALIBRATED,
        PS_SLAVE, PS_GRAND_MASTER, PS_ERROR
    } port_state_e;

    typedef enum logic [1:0] {
        SV_UNLOCKED, SV_SYNCHRONIZING, SV_LOCKED, SV_NOT_APPLICABLE
    } servo_e;

    typedef enum logic [1:0] {
        OM_OFF, OM_AUTOMATIC, OM_SLAVE_ONLY, OM_RESERVED
    } op_mode_e;

    typedef enum logic [3:0] {
        MC_SYNC, MC_DELAY_REQ, MC_PDELAY_REQ, MC_PDELAY_RESP,
        MC_FOLLOW_UP, MC_DELAY_RESP, MC_PDELAY_FUP, MC_ANNOUNCE,
        MC_SIGNALING, MC_MANAGEMENT
    } msg_cls_e;

    typedef enum logic [2:0] {
        RS_NONE, RS_MASTER, RS_GRAND_MASTER, RS_SLAVE, RS_PASSIVE
    } rec_state_e;

    typedef struct packed {
        logic     valid;
        msg_cls_e cls;
        logic     mgmt_reply;
    } msg_s;

endpackage : ptp_port_pkg

// File: ptp_port_status.sv
// Precision-time port state machine, message gating, servo status and best
// master identity. Assumes all event inputs come from logic on clk_sys_i,
// and that a register master drives one-cycle strobes.
`include "ptp_port_params.svh"

// Function
// R1 - Faulty port sends only management replies to received management.
// R2 - Port fault stays local; unconfined fault drives every port faulty.
// R3 - Disabled port sends nothing and drops all received but management.
// R4 - Disabled port never influences other ports.
// R5 - Listening waits for announce timeout or a master's announce.
// R6 - Listening sends only peer delay, signaling or management replies.
// R7 - Pre-master acts as master but sends peer delay, signaling, management.
// R8 - Master state operates fully as a master port.
// R9 - Passive sends only peer delay, signaling or management replies.
// R10 - Master selection passes through uncalibrated: servo init, data update.
// R11 - Slave state synchronizes the clock to the selected master.
// R12 - Grandmaster only in automatic mode after another device was master.
// R13 - Reported state shows error whenever any port is in error; the code shows it only while this port's state is error.
// R14 - Servo status is unlocked, synchronizing, locked or not applicable.
// R15 - The identity of the current best master is reported.
// R16 - Identity is MAC upper bytes, FFFE, then MAC lower bytes.
// R17 - Initializing sends nothing; one port initializing means all are.
// R18 - Operating mode selects off, automatic, or slave-only operation.
// R19 - Port state and servo status are readable codes at any time.
module ptp_port_status (
    input  wire logic                  clk_sys_i,
    input  wire logic                  nrst_i,
    input  wire logic [7:0]            reg_addr_i,
    input  wire logic [31:0]           reg_wdata_i,
    input  wire logic                  reg_wr_i,
    input  wire logic                  reg_rd_i,
    output logic      [31:0]           reg_rdata_o,
    input  wire ptp_port_pkg::msg_s    tx_req_i,
    output logic                       tx_grant_o,
    input  wire ptp_port_pkg::msg_s    rx_msg_i,
    output logic                       rx_accept_o,
    input  wire logic                  announce_rx_i,
    input  wire logic                  announce_tmo_i,
    input  wire logic                  qual_tmo_i,
    input  wire ptp_port_pkg::rec_state_e rec_state_i,
    input  wire logic [47:0]           master_mac_i,
    input  wire logic [47:0]           local_mac_i,
    input  wire logic                  fault_detect_i,
    input  wire logic                  fault_clear_i,
    input  wire logic                  fault_unconfined_i,
    input  wire logic                  peer_init_i,
    input  wire logic                  port_error_i,
    input  wire logic                  servo_ready_i,
    input  wire logic                  servo_locked_i,
    output logic                       servo_init_o,
    output logic                       init_all_o,
    output logic                       fault_all_o,
    output ptp_port_pkg::port_state_e  time_port_state_o,
    output ptp_port_pkg::servo_e       clock_servo_condition_o
);

    ptp_port_pkg::port_state_e state_r, state_nxt;
    ptp_port_pkg::servo_e      servo_r, servo_nxt;
    ptp_port_pkg::op_mode_e    mode_r, mode_nxt;
    logic [63:0]               best_master_identity_r, id_nxt;
    logic                      seen_master_r, seen_nxt;
    logic                      servo_init_r, servo_init_nxt;
    logic [31:0]               rdata_r, rdata_nxt;
    logic                      restart;
    logic                      active;
    logic                      reported_error;

    // Software restart of the protocol, a one-cycle pulse.
    assign restart = reg_wr_i && (reg_addr_i == `REG_CTRL_OFS)
                     && reg_wdata_i[`CTRL_RESTART_BIT];
    assign active  = (mode_r == ptp_port_pkg::OM_AUTOMATIC)
                     || (mode_r == ptp_port_pkg::OM_SLAVE_ONLY);

    // Port state transitions. Initialization and fault take priority over
    // every state decision, so no decision can slip past them.
    always_comb
    begin
        state_nxt      = state_r;
        seen_nxt       = seen_master_r;
        servo_init_nxt = 1'b0;
        if (restart || !active)
        begin
            // An off mode parks the port in disabled at once, without initializing.
            state_nxt = active ? ptp_port_pkg::PS_INITIALIZING
                               : ptp_port_pkg::PS_DISABLED;   // [R18] [R3]
            seen_nxt  = active && announce_rx_i;
        end
        else if (peer_init_i)
            state_nxt = ptp_port_pkg::PS_INITIALIZING;        // [R17]
        else if (port_error_i)
            state_nxt = ptp_port_pkg::PS_ERROR;               // [R13]
        else if (fault_detect_i || fault_unconfined_i)
            state_nxt = ptp_port_pkg::PS_FAULTY;              // [R2]
        else
        begin
            case (state_r)
                ptp_port_pkg::PS_INITIALIZING,
                ptp_port_pkg::PS_DISABLED:
                    state_nxt = ptp_port_pkg::PS_LISTENING;
                ptp_port_pkg::PS_FAULTY,
                ptp_port_pkg::PS_ERROR:
                    if (fault_clear_i)
                        state_nxt = ptp_port_pkg::PS_INITIALIZING;
                ptp_port_pkg::PS_LISTENING:
                begin
                    // Only a timeout or a master's announce leaves here.
                    if (announce_rx_i && rec_state_i == ptp_port_pkg::RS_SLAVE)
                        state_nxt = ptp_port_pkg::PS_UNCALIBRATED;    // [R5]
                    else if (announce_tmo_i
                             && mode_r == ptp_port_pkg::OM_AUTOMATIC)
                        state_nxt = ptp_port_pkg::PS_PRE_MASTER;      // [R5]
                end
                ptp_port_pkg::PS_PRE_MASTER:
                    if (qual_tmo_i)
                        state_nxt = ptp_port_pkg::PS_MASTER;          // [R7]
                ptp_port_pkg::PS_UNCALIBRATED:
                    if (servo_ready_i)
                        state_nxt = ptp_port_pkg::PS_SLAVE;           // [R10]
                default:
                    state_nxt = state_r;
            endcase
            // State decision events from the best master selection.
            if (state_r != ptp_port_pkg::PS_INITIALIZING
                && state_r != ptp_port_pkg::PS_DISABLED
                && state_r != ptp_port_pkg::PS_FAULTY
                && state_r != ptp_port_pkg::PS_ERROR
                && state_r != ptp_port_pkg::PS_LISTENING)
            begin
                case (rec_state_i)
                    // A held recommendation must not pin the transient
                    // states that their own events leave.
                    ptp_port_pkg::RS_SLAVE:
                        if (state_r != ptp_port_pkg::PS_SLAVE
                            && state_r != ptp_port_pkg::PS_UNCALIBRATED)
                            state_nxt = ptp_port_pkg::PS_UNCALIBRATED; // [R10]
                    ptp_port_pkg::RS_MASTER:
                        if (mode_r == ptp_port_pkg::OM_AUTOMATIC
                            && state_r != ptp_port_pkg::PS_MASTER
                            && state_r != ptp_port_pkg::PS_PRE_MASTER)
                            state_nxt = ptp_port_pkg::PS_PRE_MASTER;   // [R8]
                    ptp_port_pkg::RS_GRAND_MASTER:
                        if (mode_r == ptp_port_pkg::OM_AUTOMATIC
                            && seen_master_r)
                            state_nxt = ptp_port_pkg::PS_GRAND_MASTER; // [R12]
                    ptp_port_pkg::RS_PASSIVE:
                        state_nxt = ptp_port_pkg::PS_PASSIVE;          // [R9]
                    default:
                        ;
                endcase
            end
            // A foreign master seen by this port arms the grandmaster path.
            if (announce_rx_i)
                seen_nxt = 1'b1;                                       // [R12]
            if (state_nxt == ptp_port_pkg::PS_UNCALIBRATED
                && state_r != ptp_port_pkg::PS_UNCALIBRATED)
                servo_init_nxt = 1'b1;                                 // [R10]
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
        begin
            state_r       <= ptp_port_pkg::PS_INITIALIZING;
            seen_master_r <= 1'b0;
            servo_init_r  <= 1'b0;
        end
        else
        begin
            state_r       <= state_nxt;
            seen_master_r <= seen_nxt;
            servo_init_r  <= servo_init_nxt;
        end
    end

    // Servo condition follows the state; locked only while slaving.
    always_comb
    begin
        case (state_nxt)
            ptp_port_pkg::PS_UNCALIBRATED:
                servo_nxt = ptp_port_pkg::SV_UNLOCKED;                 // [R14]
            ptp_port_pkg::PS_SLAVE:
                servo_nxt = servo_locked_i ? ptp_port_pkg::SV_LOCKED
                          : ptp_port_pkg::SV_SYNCHRONIZING;            // [R11]
            default:
                servo_nxt = ptp_port_pkg::SV_NOT_APPLICABLE;           // [R14]
        endcase
    end

    // Best master identity: the selected master while slaving, else this
    // clock itself when it masters. Held otherwise so software sees history.
    always_comb
    begin
        id_nxt = best_master_identity_r;
        if (servo_init_nxt)
            id_nxt = {master_mac_i[47:24], `EUI_FILL,
                      master_mac_i[23:0]};                             // [R16]
        else if (state_nxt == ptp_port_pkg::PS_MASTER
                 || state_nxt == ptp_port_pkg::PS_GRAND_MASTER)
            id_nxt = {local_mac_i[47:24], `EUI_FILL,
                      local_mac_i[23:0]};                              // [R15]
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
        begin
            servo_r                <= ptp_port_pkg::SV_NOT_APPLICABLE;
            best_master_identity_r <= 64'h0000_0000_0000_0000;
        end
        else
        begin
            servo_r                <= servo_nxt;
            best_master_identity_r <= id_nxt;
        end
    end

    // Register port: mode is writable, control takes the restart strobe and reads zero, the rest reads back state.
    // Unmapped addresses read zero and ignore writes.
    always_comb
    begin
        mode_nxt  = mode_r;
        rdata_nxt = 32'h0000_0000;
        if (reg_wr_i && reg_addr_i == `REG_MODE_OFS)
            mode_nxt = ptp_port_pkg::op_mode_e'(reg_wdata_i[1:0]);    // [R18]
        if (reg_rd_i)
        begin
            case (reg_addr_i)
                `REG_MODE_OFS:  rdata_nxt = {30'h0, mode_r};
                `REG_STATE_OFS: rdata_nxt = {28'h0, reported_error ?
                                ptp_port_pkg::PS_ERROR : state_r};     // [R19]
                `REG_SERVO_OFS: rdata_nxt = {30'h0, servo_r};          // [R19]
                `REG_ID_HI_OFS: rdata_nxt = best_master_identity_r[63:32];
                `REG_ID_LO_OFS: rdata_nxt = best_master_identity_r[31:0];
                default:        rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
        begin
            mode_r  <= ptp_port_pkg::op_mode_e'(`MODE_RESET);
            rdata_r <= 32'h0000_0000;
        end
        else
        begin
            mode_r  <= mode_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign reported_error = (state_r == ptp_port_pkg::PS_ERROR);      // [R13]

    // Transmit gate per state. Combinational so a request is judged in the
    // same cycle it is offered; the state it reads is registered.
    always_comb
    begin
        logic peer;
        peer = tx_req_i.cls == ptp_port_pkg::MC_PDELAY_REQ
            || tx_req_i.cls == ptp_port_pkg::MC_PDELAY_RESP
            || tx_req_i.cls == ptp_port_pkg::MC_PDELAY_FUP
            || tx_req_i.cls == ptp_port_pkg::MC_SIGNALING;
        case (state_r)
            ptp_port_pkg::PS_FAULTY,
            ptp_port_pkg::PS_ERROR:
                tx_grant_o = tx_req_i.cls == ptp_port_pkg::MC_MANAGEMENT
                             && tx_req_i.mgmt_reply;                   // [R1]
            ptp_port_pkg::PS_LISTENING,
            ptp_port_pkg::PS_PASSIVE:
                tx_grant_o = peer
                    || (tx_req_i.cls == ptp_port_pkg::MC_MANAGEMENT
                        && tx_req_i.mgmt_reply);                       // [R6] [R9]
            ptp_port_pkg::PS_PRE_MASTER:
                tx_grant_o = peer
                    || tx_req_i.cls == ptp_port_pkg::MC_MANAGEMENT;    // [R7]
            ptp_port_pkg::PS_MASTER,
            ptp_port_pkg::PS_GRAND_MASTER,
            ptp_port_pkg::PS_UNCALIBRATED,
            ptp_port_pkg::PS_SLAVE:
                tx_grant_o = 1'b1;                                     // [R8] [R11]
            default:
                tx_grant_o = 1'b0;                                     // [R3] [R17]
        endcase
        tx_grant_o = tx_grant_o && tx_req_i.valid;
    end

    // Receive filter: disabled keeps only management; initializing drops all.
    always_comb
    begin
        case (state_r)
            ptp_port_pkg::PS_DISABLED:
                rx_accept_o = rx_msg_i.cls == ptp_port_pkg::MC_MANAGEMENT; // [R3]
            ptp_port_pkg::PS_INITIALIZING:
                rx_accept_o = 1'b0;
            default:
                rx_accept_o = 1'b1;
        endcase
        rx_accept_o = rx_accept_o && rx_msg_i.valid;
    end

    // Requests to other ports. A disabled port asserts neither, so it can
    // never drag a neighbour into initializing or faulty.
    assign init_all_o  = (state_r == ptp_port_pkg::PS_INITIALIZING);  // [R17] [R4]
    assign fault_all_o = (state_r == ptp_port_pkg::PS_FAULTY)
                         && fault_unconfined_i;                        // [R2] [R4]
    assign servo_init_o            = servo_init_r;
    assign reg_rdata_o             = rdata_r;
    assign time_port_state_o       = state_r;
    assign clock_servo_condition_o = servo_r;

    // Checks on the behaviour above.
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);

    // Entry steps: another state first, then the new one.
    sequence uncal_entry_seq;
        state_r != ptp_port_pkg::PS_UNCALIBRATED
        ##1 state_r == ptp_port_pkg::PS_UNCALIBRATED;
    endsequence
    sequence slave_entry_seq;
        state_r != ptp_port_pkg::PS_SLAVE
        ##1 state_r == ptp_port_pkg::PS_SLAVE;
    endsequence

    faulty_tx_only_a: assert property (                                // [R1]
        state_r == ptp_port_pkg::PS_FAULTY && tx_grant_o
        |-> tx_req_i.cls == ptp_port_pkg::MC_MANAGEMENT && tx_req_i.mgmt_reply)
        else $error("Faulty port sent a non-reply message.");
    disabled_silent_a: assert property (                               // [R3]
        state_r == ptp_port_pkg::PS_DISABLED |-> !tx_grant_o
        && (!rx_accept_o || rx_msg_i.cls == ptp_port_pkg::MC_MANAGEMENT))
        else $error("Disabled port sent or accepted a message.");
    init_silent_a: assert property (                                   // [R17]
        state_r == ptp_port_pkg::PS_INITIALIZING |-> !tx_grant_o && init_all_o)
        else $error("Initializing port sent a message.");
    listen_tx_a: assert property (                                     // [R6]
        state_r == ptp_port_pkg::PS_LISTENING && tx_grant_o
        |-> tx_req_i.cls != ptp_port_pkg::MC_SYNC
        && tx_req_i.cls != ptp_port_pkg::MC_ANNOUNCE
        && tx_req_i.cls != ptp_port_pkg::MC_DELAY_REQ)
        else $error("Listening port sent an event message.");
    premaster_tx_a: assert property (                                  // [R7]
        state_r == ptp_port_pkg::PS_PRE_MASTER && tx_req_i.valid
        && tx_req_i.cls == ptp_port_pkg::MC_ANNOUNCE |-> !tx_grant_o)
        else $error("Pre-master port sent an announce.");
    grand_master_a: assert property (                                  // [R12]
        state_r == ptp_port_pkg::PS_GRAND_MASTER
        && $past(state_r) != ptp_port_pkg::PS_GRAND_MASTER
        |-> $past(mode_r) == ptp_port_pkg::OM_AUTOMATIC && $past(seen_master_r))
        else $error("Grandmaster reached without a prior master.");
    error_report_a: assert property (                                  // [R13]
        port_error_i && active && !restart && !peer_init_i
        ##1 reg_rd_i && reg_addr_i == `REG_STATE_OFS
        |=> rdata_r[3:0] == ptp_port_pkg::PS_ERROR)
        else $error("Port error not reported.");
    uncal_first_a: assert property (                                   // [R10]
        slave_entry_seq
        |-> $past(state_r) == ptp_port_pkg::PS_UNCALIBRATED
        && $past(servo_ready_i))
        else $error("Slave entered without uncalibrated.");
    servo_init_a: assert property (                                    // [R10]
        uncal_entry_seq |-> servo_init_o
        && best_master_identity_r[39:24] == `EUI_FILL)
        else $error("Uncalibrated entry did not init servo.");
    servo_na_a: assert property (                                      // [R14]
        state_r != ptp_port_pkg::PS_SLAVE
        && state_r != ptp_port_pkg::PS_UNCALIBRATED
        |-> servo_r == ptp_port_pkg::SV_NOT_APPLICABLE)
        else $error("Servo status applies outside slave.");

endmodule : ptp_port_status

// File: remote_clock_model.sv
// Behavioural stand-in for the remote time-protocol clock on the network.
// Assumes the bench drives offer_i and passive_i after rising clock edges.
module remote_clock_model (
    input  wire logic                     clk_sys_i,
    input  wire logic                     offer_i,
    input  wire logic                     passive_i,
    input  wire logic                     gm_i,
    input  wire logic [47:0]              mac_i,
    output logic                          announce_rx_o,
    output ptp_port_pkg::rec_state_e      rec_state_o,
    output logic      [47:0]              mac_o
);
    timeunit 1ns;
    timeprecision 1ns;

    logic offer_q;

    // Remember the offer so that one announce is sent per offer, not a stream.
    always_ff @(posedge clk_sys_i)
    begin
        offer_q <= offer_i;
    end

    // A grandmaster recommendation wins; a master offering itself
    // recommends slave; otherwise passive or idle.
    assign announce_rx_o = offer_i & ~offer_q;
    assign rec_state_o   = gm_i ? ptp_port_pkg::RS_GRAND_MASTER :
                           offer_i ? ptp_port_pkg::RS_SLAVE :
                           (passive_i ? ptp_port_pkg::RS_PASSIVE :
                            ptp_port_pkg::RS_NONE);
    assign mac_o         = mac_i;
endmodule : remote_clock_model

// File: ptp_port_status_tb.sv
// Self-checking bench for the port status block with a remote clock model.
// Assumes a 10 MHz clock and the register offsets of the shared header.
`include "ptp_port_params.svh"
module ptp_port_status_tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk_sys_i = 1'b0, nrst_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o;
    ptp_port_pkg::msg_s tx_req_i = '0, rx_msg_i = '0;
    logic [3:0] ev = 4'h0;
    logic offer = 1'b0, passive = 1'b0, port_error_i = 1'b0, peer_init_i = 1'b0;
    logic fault_unconfined_i = 1'b0, servo_ready_i = 1'b0;
    logic servo_locked_i = 1'b0, gm = 1'b0;
    logic [47:0] mac = 48'h0, local_mac_i = 48'h0, master_mac_i;
    logic tx_grant_o, rx_accept_o, announce_rx_i, servo_init_o;
    logic init_all_o, fault_all_o;
    ptp_port_pkg::rec_state_e rec_state_i;
    ptp_port_pkg::port_state_e time_port_state_o;
    ptp_port_pkg::servo_e clock_servo_condition_o;
    int bad_count = 0, total_checks = 0, cycles = 0, model_st = 0;

    // Free-running system clock, 100 ns period.
    always #50 clk_sys_i = ~clk_sys_i;

    remote_clock_model i_far (.clk_sys_i(clk_sys_i), .offer_i(offer),
        .passive_i(passive), .gm_i(gm), .mac_i(mac),
        .announce_rx_o(announce_rx_i),
        .rec_state_o(rec_state_i), .mac_o(master_mac_i));

    ptp_port_status i_dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .tx_req_i(tx_req_i), .tx_grant_o(tx_grant_o), .rx_msg_i(rx_msg_i),
        .rx_accept_o(rx_accept_o), .announce_rx_i(announce_rx_i),
        .announce_tmo_i(ev[2]), .qual_tmo_i(ev[3]), .rec_state_i(rec_state_i),
        .master_mac_i(master_mac_i), .local_mac_i(local_mac_i),
        .fault_detect_i(ev[0]), .fault_clear_i(ev[1]),
        .fault_unconfined_i(fault_unconfined_i), .peer_init_i(peer_init_i),
        .port_error_i(port_error_i), .servo_ready_i(servo_ready_i),
        .servo_locked_i(servo_locked_i), .servo_init_o(servo_init_o),
        .init_all_o(init_all_o), .fault_all_o(fault_all_o),
        .time_port_state_o(time_port_state_o),
        .clock_servo_condition_o(clock_servo_condition_o));

    // Transmit permission per state code, as the gating rules read.
    function automatic bit exp_tx(input int st, input int c, input bit r);
        bit peer = (c == 2) || (c == 3) || (c == 6) || (c == 8);
        bit mg   = (c == 9);
        case (st)
            0, 2:    return 1'b0;
            1, 10:   return mg && r;
            3, 6:    return peer || (mg && r);
            4:       return peer || mg;
            default: return 1'b1;
        endcase
    endfunction : exp_tx

    // Receive acceptance: initializing drops all, disabled keeps management.
    function automatic bit exp_rx(input int st, input int c);
        return (st == 0) ? 1'b0 : ((st == 2) ? (c == 9) : 1'b1);
    endfunction : exp_rx

    // Prints the counts and the verdict, then stops the run.
    task finish_test;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : finish_test

    task check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Register bus cycles; read data stand only in the cycle after the strobe.
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
    endtask : wr

    task rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        #1 check(reg_rdata_o, exp);
        @(posedge clk_sys_i);
        #1 check(reg_rdata_o, 32'h0);
    endtask : rd

    task pulse(input int i);
        @(posedge clk_sys_i);
        ev[i] <= 1'b1;
        @(posedge clk_sys_i);
        ev <= 4'h0;
    endtask : pulse

    // Waits a bounded number of edges for the state, then compares it.
    task wait_state(input int exp);
        int n;
        n = 0;
        do
        begin
            @(posedge clk_sys_i);
            #1 n++;
        end
        while (time_port_state_o !== 4'(exp) && n < 6);
        model_st = exp;
        check(time_port_state_o, exp);
    endtask : wait_state

    // Offers every class with and without the reply flag in the state held.
    task sweep;
        for (int c = 0; c < 10; c++)
            for (int r = 0; r < 2; r++)
            begin
                @(posedge clk_sys_i);
                tx_req_i <= '{1'b1, ptp_port_pkg::msg_cls_e'(c), r[0]};
                rx_msg_i <= '{1'b1, ptp_port_pkg::msg_cls_e'(c), r[0]};
                #1 check(tx_grant_o, exp_tx(model_st, c, r[0]));
                check(rx_accept_o, exp_rx(model_st, c));
            end
        @(posedge clk_sys_i);
        tx_req_i <= '0;
        rx_msg_i <= '0;
    endtask : sweep

    // A hang is cut short well above the few hundred cycles the run needs.
    always @(posedge clk_sys_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            bad_count++;
            finish_test();
        end
    end

    // Main sequence.
    initial
    begin
        void'($urandom(32'h89CA));
        mac = {16'($urandom), $urandom};
        local_mac_i = {16'($urandom), $urandom};
        repeat (9) @(posedge clk_sys_i);
        #1 check(time_port_state_o, 32'h0);
        check(clock_servo_condition_o, 32'h3);
        check(init_all_o, 32'h1);
        @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        wait_state(3);
        rd(`REG_MODE_OFS, 32'h1);
        rd(`REG_STATE_OFS, 32'h3);
        rd(8'h40, 32'h0);
        sweep();
        @(posedge clk_sys_i);
        offer <= 1'b1;
        @(posedge clk_sys_i);
        #1 check(time_port_state_o, 32'h7);
        check(servo_init_o, 32'h1);
        check(clock_servo_condition_o, 32'h0);
        @(posedge clk_sys_i);
        #1 check(servo_init_o, 32'h0);
        servo_ready_i <= 1'b1;
        wait_state(8);
        check(clock_servo_condition_o, 32'h1);
        servo_locked_i <= 1'b1;
        @(posedge clk_sys_i);
        #1 check(clock_servo_condition_o, 32'h2);
        rd(`REG_SERVO_OFS, 32'h2);
        rd(`REG_ID_HI_OFS, {mac[47:24], 8'(`EUI_FILL >> 8)});
        rd(`REG_ID_LO_OFS, {8'(`EUI_FILL), mac[23:0]});
        sweep();
        offer <= 1'b0;
        passive <= 1'b1;
        servo_ready_i <= 1'b0;
        wait_state(6);
        sweep();
        passive <= 1'b0;
        pulse(0);
        wait_state(1);
        fault_unconfined_i <= 1'b1;
        @(posedge clk_sys_i);
        #1 check(fault_all_o, 32'h1);
        sweep();
        fault_unconfined_i <= 1'b0;
        pulse(1);
        wait_state(3);
        port_error_i <= 1'b1;
        wait_state(10);
        rd(`REG_STATE_OFS, 32'hA);
        sweep();
        port_error_i <= 1'b0;
        pulse(1);
        wait_state(3);
        peer_init_i <= 1'b1;
        wait_state(0);
        check(init_all_o, 32'h1);
        sweep();
        peer_init_i <= 1'b0;
        wait_state(3);
        wr(`REG_MODE_OFS, 32'h0);
        wait_state(2);
        check(init_all_o | fault_all_o, 32'h0);
        rd(`REG_MODE_OFS, 32'h0);
        sweep();
        wr(`REG_MODE_OFS, 32'h1);
        wait_state(3);
        pulse(2);
        wait_state(4);
        sweep();
        pulse(3);
        wait_state(5);
        sweep();
        gm <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        #1 check(time_port_state_o, 32'h5);
        rd(`REG_ID_LO_OFS, {8'(`EUI_FILL), local_mac_i[23:0]});
        offer <= 1'b1;
        wait_state(9);
        offer <= 1'b0;
        gm <= 1'b0;
        wr(`REG_CTRL_OFS, 32'h1);
        #1 check(time_port_state_o, 32'h0);
        wait_state(3);
        wr(`REG_MODE_OFS, 32'h2);
        pulse(2);
        #1 check(time_port_state_o, 32'h3);
        finish_test();
    end
endmodule : ptp_port_status_tb
